// ---- logic/ascv_pkg.sv ----
package ascv_pkg;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	// shortest half period of the serial clock (5 MHz ceiling)
	localparam int SCLK_HALF_NS = 100;
	// enable setup, hold and abort guard
	localparam int EN_GUARD_NS = 50;
	localparam int SCLK_HALF_CYC =
		(SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EN_GUARD_CYC =
		(EN_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// "longer than" the guard: one cycle beyond its rounded length
	localparam int EN_ABORT_CYC = EN_GUARD_CYC + 1;

	// ---------------------------------------------------------------
	// serial word
	// ---------------------------------------------------------------
	localparam int WORD_BITS = 8;
	localparam int VOL_BITS = 5;
	localparam int ATT_BITS = 7;
	localparam logic [3:0] BIT_CNT_LAST = 4'h7;
	// upper three bits of a word select its target
	localparam logic [2:0] SEL_CTRL = 3'h0;
	localparam logic [2:0] SEL_VOLUME = 3'h3;
	// control word field positions
	localparam int POS_POWER_DOWN = 0;
	localparam int POS_MUTE = 1;
	localparam int POS_VOL_MODE = 2;
	localparam int POS_GAIN_EXT = 3;
	localparam int POS_HP_MODE = 4;
	localparam logic [4:0] CTRL_RESET = 5'h00;
	localparam logic [4:0] VOL_RESET = 5'h00;
	// idle pin levels {beep, sense, data, enable, clock}: only enable
	// idles high, so no false clock edge or sense follows reset
	localparam logic [4:0] SYNC_IDLE = 5'h02;

	// attenuation magnitude in dB for each volume code
	localparam logic [ATT_BITS-1:0] ATT_TABLE [32] = '{
		7'h5A, 7'h5A, 7'h44, 7'h3F, 7'h39, 7'h33, 7'h2F, 7'h2D,
		7'h2A, 7'h27, 7'h24, 7'h22, 7'h20, 7'h1E, 7'h1C, 7'h1A,
		7'h18, 7'h16, 7'h14, 7'h12, 7'h10, 7'h0E, 7'h0C, 7'h0A,
		7'h08, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01, 7'h00
	};

	// ---------------------------------------------------------------
	// controller registers (APB)
	// ---------------------------------------------------------------
	localparam int APB_ADDR_W = 12;
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam int POS_BUSY = 0;

	typedef enum logic [2:0] {
		ASCV_IDLE,
		ASCV_SETUP,
		ASCV_LOW,
		ASCV_HIGH,
		ASCV_HOLD,
		ASCV_GAP
	} ascv_state_t;

endpackage

// ---- logic/ascv_if.sv ----
interface ascv_if;
	logic sclk;
	logic enableN;
	logic sdata;

	modport host (
		output sclk,
		output enableN,
		output sdata
	);

	modport dev (
		input sclk,
		input enableN,
		input sdata
	);
endinterface

// ---- logic/ascv_device.sv ----
module ascv_device (
	// system
	input wire logic clk,
	input wire logic rst,
	// serial link
	ascv_if.dev link,
	// analog-side detector pins
	input wire logic headphoneDetectPin,
	input wire logic beepDetect,
	// amplifier controls
	output logic ampActive,
	output logic ampMute,
	output logic dockMute,
	output logic headphoneMode,
	output logic outputsInPhase,
	output logic gainExternal,
	output logic volumeActive,
	output logic [ascv_pkg::VOL_BITS-1:0] volumeCode,
	output logic [ascv_pkg::ATT_BITS-1:0] attenDb,
	output logic wordStrobe
);
	import ascv_pkg::*;

	// ---------------------------------------------------------------
	// synchronisers
	// ---------------------------------------------------------------
	logic [4:0] syncA_q;
	logic [4:0] syncB_q;
	logic sclkPrev_q;
	logic sclkS;
	logic enNS;
	logic dataS;
	logic hpPinS;
	logic beepS;
	logic sclkRise;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncA_q <= SYNC_IDLE;
			syncB_q <= SYNC_IDLE;
			sclkPrev_q <= 1'b0;
		end else begin
			syncA_q <= {beepDetect, headphoneDetectPin, link.sdata,
				link.enableN, link.sclk};
			syncB_q <= syncA_q;
			sclkPrev_q <= syncB_q[0];
		end
	end

	assign sclkS = syncB_q[0];
	assign enNS = syncB_q[1];
	assign dataS = syncB_q[2];
	assign hpPinS = syncB_q[3];
	assign beepS = syncB_q[4];
	assign sclkRise = sclkS & ~sclkPrev_q;

	// ---------------------------------------------------------------
	// enable abort filter
	// ---------------------------------------------------------------
	// a short high glitch on enable keeps the partial word; only a
	// high phase longer than the guard time throws it away
	logic [3:0] enHighCnt_q;
	logic abortWord;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enHighCnt_q <= 4'h0;
		end else if (!enNS) begin
			enHighCnt_q <= 4'h0;
		end else if (enHighCnt_q != 4'(EN_ABORT_CYC)) begin
			enHighCnt_q <= enHighCnt_q + 4'h1;
		end
	end

	assign abortWord = (enHighCnt_q == 4'(EN_ABORT_CYC));

	// ---------------------------------------------------------------
	// shift register
	// ---------------------------------------------------------------
	logic [WORD_BITS-1:0] shift_q;
	logic [WORD_BITS-1:0] shiftNext;
	logic [3:0] bitCnt_q;
	logic wordDone_q;
	logic wordFull;

	assign shiftNext = {shift_q[WORD_BITS-2:0], dataS};
	assign wordFull = sclkRise & ~enNS & ~wordDone_q &
		(bitCnt_q == BIT_CNT_LAST);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_q <= '0;
			bitCnt_q <= 4'h0;
			wordDone_q <= 1'b0;
		end else if (abortWord) begin
			bitCnt_q <= 4'h0;
			wordDone_q <= 1'b0;
		end else if (sclkRise && !enNS && !wordDone_q) begin
			shift_q <= shiftNext;
			if (bitCnt_q == BIT_CNT_LAST) begin
				wordDone_q <= 1'b1;
				bitCnt_q <= 4'h0;
			end else begin
				bitCnt_q <= bitCnt_q + 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// control fields
	// ---------------------------------------------------------------
	logic [4:0] ctrl_q;
	logic [VOL_BITS-1:0] vol_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			vol_q <= VOL_RESET;
		end else if (wordFull) begin
			unique case (shiftNext[7:5])
				SEL_CTRL: ctrl_q <= shiftNext[4:0];
				SEL_VOLUME: vol_q <= shiftNext[VOL_BITS-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wordStrobe <= 1'b0;
		end else begin
			wordStrobe <= wordFull;
		end
	end

	// ---------------------------------------------------------------
	// amplifier outputs
	// ---------------------------------------------------------------
	// outputs trail the fields by one cycle so every port leaves a
	// flip-flop; a change on the sense pin appears after the
	// two-stage synchroniser plus this stage
	logic hpNow;

	assign hpNow = hpPinS | ctrl_q[POS_HP_MODE];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			headphoneMode <= 1'b0;
			outputsInPhase <= 1'b0;
		end else begin
			headphoneMode <= hpNow;
			outputsInPhase <= hpNow;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ampActive <= 1'b0;
			ampMute <= 1'b0;
			dockMute <= 1'b0;
		end else begin
			ampActive <= ctrl_q[POS_POWER_DOWN];
			ampMute <= ctrl_q[POS_MUTE] & ~beepS;
			dockMute <= ctrl_q[POS_MUTE];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gainExternal <= 1'b0;
		end else begin
			gainExternal <= ctrl_q[POS_GAIN_EXT];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			volumeActive <= 1'b0;
			volumeCode <= VOL_RESET;
			attenDb <= '0;
		end else begin
			volumeCode <= vol_q;
			volumeActive <= ctrl_q[POS_VOL_MODE];
			if (ctrl_q[POS_VOL_MODE]) begin
				attenDb <= ATT_TABLE[vol_q];
			end else begin
				attenDb <= '0;
			end
		end
	end

endmodule // ascv_device

// ---- logic/ascv_host.sv ----
module ascv_host #(
	parameter int HALF_CYC = ascv_pkg::SCLK_HALF_CYC
) (
	// system
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ascv_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	ascv_if.host link
);
	import ascv_pkg::*;

	// faster than this would break the 5 MHz ceiling
	if (HALF_CYC < SCLK_HALF_CYC || HALF_CYC > 255) begin : g_bad_half
		$error("ascv_host: HALF_CYC out of range");
	end

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	ascv_state_t state_q;
	logic [WORD_BITS-1:0] word_q;
	logic busy;
	logic wrAccess;
	logic startReq;
	logic mapped;

	assign busy = (state_q != ASCV_IDLE);
	assign mapped = (paddr == OFS_CMD) || (paddr == OFS_STATUS);
	assign wrAccess = psel & penable & pready & pwrite;
	// a command while a word is on the wire is dropped
	assign startReq = wrAccess & (paddr == OFS_CMD) & ~busy;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= ~mapped;
			if (paddr == OFS_CMD) begin
				prdata <= {24'h00_0000, word_q};
			end else if (paddr == OFS_STATUS) begin
				prdata <= {31'h0000_0000, busy};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			word_q <= '0;
		end else if (startReq) begin
			word_q <= pwdata[WORD_BITS-1:0];
		end
	end

	// ---------------------------------------------------------------
	// phase timer
	// ---------------------------------------------------------------
	logic [7:0] tick_q;
	logic tick;

	assign tick = (tick_q == 8'(HALF_CYC - 1));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_q <= 8'h00;
		end else if (!busy || tick) begin
			tick_q <= 8'h00;
		end else begin
			tick_q <= tick_q + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// link sequencer
	// ---------------------------------------------------------------
	logic [3:0] bitIdx_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ASCV_IDLE;
			bitIdx_q <= 4'h0;
		end else begin
			unique case (state_q)
				ASCV_IDLE: begin
					bitIdx_q <= 4'h0;
					if (startReq) begin
						state_q <= ASCV_SETUP;
					end
				end
				ASCV_SETUP: if (tick) state_q <= ASCV_LOW;
				ASCV_LOW: if (tick) state_q <= ASCV_HIGH;
				ASCV_HIGH: begin
					if (tick) begin
						if (bitIdx_q == BIT_CNT_LAST) begin
							state_q <= ASCV_HOLD;
						end else begin
							bitIdx_q <= bitIdx_q + 4'h1;
							state_q <= ASCV_LOW;
						end
					end
				end
				ASCV_HOLD: if (tick) state_q <= ASCV_GAP;
				ASCV_GAP: if (tick) state_q <= ASCV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link.sclk <= 1'b0;
			link.enableN <= 1'b1;
			link.sdata <= 1'b0;
		end else begin
			// half period at least 100 ns
			link.sclk <= (state_q == ASCV_HIGH);
			// enable low only for the word
			link.enableN <= (state_q == ASCV_IDLE) ||
				(state_q == ASCV_GAP);
			link.sdata <= word_q[3'(BIT_CNT_LAST - bitIdx_q)];
		end
	end

endmodule // ascv_host

// ---- tb/ascv_checker.sv ----
module ascv_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial link
	input wire logic sclk,
	input wire logic enableN,
	input wire logic sdata
);
	timeunit 1ns;
	timeprecision 1ns;
	import ascv_pkg::*;
	logic sclkOld_q;
	logic [3:0] riseCnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// --------
	// frame bookkeeping
	// --------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclkOld_q <= 1'b0;
			riseCnt_q <= 4'h0;
		end else begin
			sclkOld_q <= sclk;
			if (enableN)
				riseCnt_q <= 4'h0;
			else if (sclk && !sclkOld_q)
				riseCnt_q <= riseCnt_q + 4'h1;
		end
	end
	sequence s_high_half;
		sclk [*5];
	endsequence
	sequence s_low_half;
		!sclk [*5];
	endsequence
	// --------
	// link checks
	// --------
	a_sclk_high_min: assert property (
		$rose(sclk) |-> s_high_half) else $error("sclk high too short");
	a_sclk_low_min: assert property (
		$fell(sclk) |-> s_low_half) else $error("sclk low too short");
	a_no_coincide: assert property (
		!($changed(sclk) && $changed(enableN)))
		else $error("sclk and enable moved together");
	a_sclk_framed: assert property (
		sclk |-> !enableN) else $error("sclk high outside frame");
	a_enable_setup: assert property (
		$rose(sclk) |-> $past(enableN, 3) == 1'b0)
		else $error("enable setup too short");
	a_enable_hold: assert property (
		$rose(enableN) |-> $past(sclk, 3) == 1'b0)
		else $error("enable hold too short");
	a_enable_gap: assert property (
		$rose(enableN) |-> enableN [*3]) else $error("enable gap short");
	a_data_setup: assert property (
		$rose(sclk) |-> $stable(sdata) && sdata == $past(sdata, 3))
		else $error("data setup too short");
	a_data_hold: assert property (
		sclk && $past(sclk) |-> $stable(sdata))
		else $error("data moved while sclk high");
	a_eight_bits: assert property (
		$rose(enableN) |-> riseCnt_q == 4'h8) else $error("not 8 bits");
endmodule // ascv_checker

// ---- tb/amp_serial_control_volume_tb_top.sv ----
module amp_serial_control_volume_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ascv_pkg::*;
	localparam logic [6:0] LOW_ATT [10] = '{7'h5A, 7'h5A, 7'h44, 7'h3F,
		7'h39, 7'h33, 7'h2F, 7'h2D, 7'h2A, 7'h27};
	logic clk, rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic hpPin, beep, aAct, aMute, dMute, hpMode, inPh, gExt, vAct;
	logic [4:0] volCode, volCode2;
	logic [6:0] attenDb;
	logic strobe, strobe2;
	logic [7:0] wireBits;
	int fail_count, samples_checked, cycles, nStb, nStb2, n;
	ascv_if link ();
	ascv_if l2 ();
	ascv_host u_ascv_host (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link.host));
	ascv_device u_ascv_device (.clk(clk), .rst(rst), .link(link.dev),
		.headphoneDetectPin(hpPin), .beepDetect(beep), .ampActive(aAct),
		.ampMute(aMute), .dockMute(dMute), .headphoneMode(hpMode),
		.outputsInPhase(inPh), .gainExternal(gExt), .volumeActive(vAct),
		.volumeCode(volCode), .attenDb(attenDb), .wordStrobe(strobe));
	// second device faces a bench driver that breaks framing on purpose
	ascv_device u_ascv_device_2 (.clk(clk), .rst(rst), .link(l2.dev),
		.headphoneDetectPin(1'b0), .beepDetect(1'b0), .ampActive(),
		.ampMute(), .dockMute(), .headphoneMode(), .outputsInPhase(),
		.gainExternal(), .volumeActive(), .volumeCode(volCode2),
		.attenDb(), .wordStrobe(strobe2));
	ascv_checker u_ascv_checker (.clk(clk), .rst(rst), .sclk(link.sclk),
		.enableN(link.enableN), .sdata(link.sdata));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (strobe === 1'b1) nStb <= nStb + 1;
		if (strobe2 === 1'b1) nStb2 <= nStb2 + 1;
		if (cycles == 30000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	always @(posedge link.sclk)
		if (link.enableN === 1'b0) wireBits <= {wireBits[6:0], link.sdata};
	// --------
	// helpers
	// --------
	task chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task send(input logic [7:0] w);
		apb(1'b1, OFS_CMD, {24'h0, w});
		rdat = 32'h1;
		while (rdat[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
		chk("wire", wireBits, w);
	endtask
	task bang(input logic [15:0] w, input int nb);
		l2.enableN <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			l2.sdata <= w[15-i];
			repeat (4) @(posedge clk);
			l2.sclk <= 1'b1;
			repeat (4) @(posedge clk);
			l2.sclk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		l2.enableN <= 1'b1;
		l2.sdata <= ~l2.sdata;
		repeat (12) @(posedge clk);
	endtask
	function automatic logic [6:0] att(input int c);
		if (c < 10) return LOW_ATT[c];
		if (c < 16) return 7'(36 - 2 * (c - 10));
		if (c < 25) return 7'(2 * (28 - c));
		return 7'(31 - c);
	endfunction
	// --------
	// scenarios
	// --------
	task t_reset;
		chk("ctl", {aAct, aMute, dMute, hpMode, inPh, gExt, vAct}, 0);
		chk("vol", volCode, 0);
		apb(1'b0, 12'h008, 32'h0);
		chk("slverr", rerr, 1);
		$display("test reset done");
	endtask
	task t_ctrl;
		send(8'h1F);
		chk("all", {aAct, aMute, dMute, hpMode, inPh, gExt, vAct}, 7'h7F);
		beep <= 1'b1;
		repeat (8) @(posedge clk);
		chk("beep", {aAct, aMute, dMute, hpMode, inPh, gExt, vAct}, 7'h5F);
		beep <= 1'b0;
		send(8'h08);
		chk("gain", {aAct, aMute, dMute, hpMode, inPh, gExt, vAct}, 7'h02);
		hpPin <= 1'b1;
		repeat (8) @(posedge clk);
		chk("sense", {aAct, aMute, dMute, hpMode, inPh, gExt, vAct}, 7'h0E);
		hpPin <= 1'b0;
		$display("test control done");
	endtask
	task t_vol;
		send(8'h05);
		for (int c = 0; c < 32; c++) begin
			send({3'h3, 5'(c)});
			chk("code", volCode, c);
			chk("atten", attenDb, att(c));
		end
		send(8'h01);
		chk("fixed", {vAct, attenDb}, 0);
		n = nStb;
		send(8'h55);
		chk("steer", {volCode, 16'(nStb)}, {5'h1F, 16'(n + 1)});
		apb(1'b0, OFS_CMD, 32'h0);
		chk("readback", rdat, 32'h0000_0055);
		$display("test volume done");
	endtask
	task t_link2;
		n = nStb2;
		bang(16'h6000, 3);
		bang(16'h6A00, 8);
		chk("abort", {volCode2, 16'(nStb2)}, {5'h0A, 16'(n + 1)});
		// a receiver that kept shifting would land on code 0F
		bang(16'h6DE0, 11);
		chk("extra", {volCode2, 16'(nStb2)}, {5'h0D, 16'(n + 2)});
		$display("test framing done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, hpPin, beep} = '0;
		{l2.sclk, l2.enableN, l2.sdata} = 3'h2;
		{fail_count, samples_checked, cycles, nStb, nStb2} = '0;
		wireBits = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_ctrl();
		t_vol();
		t_link2();
		tally_and_finish();
	end
endmodule // amp_serial_control_volume_tb_top
